// >>> rtl/rpd_pkg.sv
// shared constants and types for the rank power-down controller
package rpd_pkg;

  localparam int unsigned NUM_RANKS = 4;

  // register byte offsets
  localparam logic [7:0] OFF_PD_CFG    = 8'h00;
  localparam logic [7:0] OFF_CTRL      = 8'h04;
  localparam logic [7:0] OFF_POP       = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_EXIT_LAT  = 8'h10;

  // power-down configuration fields
  localparam int unsigned TYPE_MSB     = 15;
  localparam int unsigned TYPE_LSB     = 12;
  localparam int unsigned IDLE_MSB     = 11;
  localparam int unsigned IDLE_LSB     = 0;

  // control register bits
  localparam int unsigned CTRL_CKE_REL = 0;
  localparam int unsigned CTRL_LOCK    = 1;

  // reset values
  localparam logic [15:0] PD_CFG_RST   = 16'h0000;
  localparam logic [3:0]  POP_RST      = 4'hf;
  localparam logic [4:0]  TXP_RST      = 5'h04;
  localparam logic [4:0]  TXPDLL_RST   = 5'h14;

  typedef enum logic [3:0] {
    RPD_MODE_NONE      = 4'h0,
    RPD_MODE_ACTIVE    = 4'h1,
    RPD_MODE_PRECHARGE = 4'h2,
    RPD_MODE_DLL_OFF   = 4'h6
  } rpd_mode_t;

  typedef enum logic [1:0] {
    RPD_ST_UP    = 2'b00,
    RPD_ST_PREP  = 2'b01,
    RPD_ST_DOWN  = 2'b10,
    RPD_ST_EXIT  = 2'b11
  } rpd_state_t;

endpackage

// >>> rtl/rpd_if.sv
// per-rank shared signals between the top and a rank engine
`timescale 1ns/1ps
interface rpd_if;
  logic                    cke_release;
  logic [3:0]              mode;
  logic [11:0]             idle_thresh;
  logic [4:0]              txp;
  logic [4:0]              txpdll;
  logic                    req;
  logic                    banks_closed;
  logic                    cke;
  logic                    ready;
  logic                    precharge_req;
  logic                    pages_lost;
  logic                    powered_down;
  modport ctl (output cke_release, mode, idle_thresh, txp, txpdll, req, banks_closed,
               input cke, ready, precharge_req, pages_lost, powered_down);
  modport eng (input cke_release, mode, idle_thresh, txp, txpdll, req, banks_closed,
               output cke, ready, precharge_req, pages_lost, powered_down);
endinterface

// >>> rtl/rpd_rank.sv
// power-down engine for one rank: idle counter, entry and exit timing
`timescale 1ns/1ps
module rpd_rank (
  input  wire logic CLK,
  input  wire logic RST_N,
  rpd_if.eng        rif
);

  typedef struct packed {
    rpd_pkg::rpd_state_t st;
    logic [11:0]         idle;
    logic [4:0]          wait_cnt;
    logic                cke;
    logic                lost;
  } rpd_rank_t;

  rpd_rank_t cur;
  rpd_rank_t next_cur;

  logic pd_enabled;
  logic precharge_mode;

  assign pd_enabled     = (rif.mode == rpd_pkg::RPD_MODE_ACTIVE) ||
                          (rif.mode == rpd_pkg::RPD_MODE_PRECHARGE) ||
                          (rif.mode == rpd_pkg::RPD_MODE_DLL_OFF);
  assign precharge_mode = (rif.mode == rpd_pkg::RPD_MODE_PRECHARGE) ||
                          (rif.mode == rpd_pkg::RPD_MODE_DLL_OFF);

  always_comb begin
    next_cur = cur;
    if (!rif.cke_release) begin
      // cke held low until software releases it
      next_cur.st       = rpd_pkg::RPD_ST_UP;
      next_cur.cke      = 1'b0; // see R16 R17
      next_cur.idle     = 12'h000;
      next_cur.wait_cnt = 5'h00;
    end else begin
      case (cur.st)
        rpd_pkg::RPD_ST_UP: begin
          next_cur.cke = 1'b1;
          if (rif.req) begin
            next_cur.idle = 12'h000; // see R12
            next_cur.lost = 1'b0;
          end else if (cur.idle != 12'hfff) begin
            next_cur.idle = cur.idle + 12'h001; // see R11 R13
          end
          if (cur.cke && pd_enabled && !rif.req && cur.idle >= rif.idle_thresh) begin
            next_cur.st = precharge_mode ? rpd_pkg::RPD_ST_PREP : rpd_pkg::RPD_ST_DOWN;
            if (!precharge_mode) begin
              next_cur.cke = 1'b0; // see R08
            end
          end
        end
        rpd_pkg::RPD_ST_PREP: begin
          if (rif.req) begin
            next_cur.st   = rpd_pkg::RPD_ST_UP;
            next_cur.idle = 12'h000;
          end else if (rif.banks_closed) begin
            next_cur.st   = rpd_pkg::RPD_ST_DOWN; // see R10
            next_cur.cke  = 1'b0;
            next_cur.lost = 1'b1;
          end
        end
        rpd_pkg::RPD_ST_DOWN: begin
          if (rif.req || !pd_enabled) begin
            next_cur.cke      = 1'b1; // see R18
            next_cur.st       = rpd_pkg::RPD_ST_EXIT;
            // dll-off waits txpdll instead of txp before data moves, even where txp is longer
            next_cur.wait_cnt = (rif.mode == rpd_pkg::RPD_MODE_DLL_OFF) ? rif.txpdll
                                                                        : rif.txp; // see R09
          end
        end
        rpd_pkg::RPD_ST_EXIT: begin
          if (cur.wait_cnt > 5'h01) begin
            next_cur.wait_cnt = cur.wait_cnt - 5'h01; // see R08 R10 R18
          end else begin
            next_cur.wait_cnt = 5'h00;
            next_cur.st       = rpd_pkg::RPD_ST_UP;
            next_cur.idle     = 12'h000;
          end
        end
        default: next_cur.st = rpd_pkg::RPD_ST_UP;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= '{st: rpd_pkg::RPD_ST_UP, idle: 12'h000, wait_cnt: 5'h00, cke: 1'b0, lost: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign rif.cke           = cur.cke;
  assign rif.ready         = (cur.st == rpd_pkg::RPD_ST_UP) && cur.cke;
  assign rif.precharge_req = (cur.st == rpd_pkg::RPD_ST_PREP);
  assign rif.pages_lost    = cur.lost;
  assign rif.powered_down  = (cur.st == rpd_pkg::RPD_ST_DOWN);

endmodule

// >>> rtl/rpd_top.sv
// rank power-down controller top: apb registers, pad enables, rank engines
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R01: ranks without devices get clock, cke, odt and chip select undriven.
// R02: after reset every rank counts as populated and is driven.
// R03: software only floats cke for ranks known to be empty.
// R04: four independent cke outputs, one per rank.
// R05: power-down type sits in config bits 15:12.
// R06: twelve-bit idle threshold sits in config bits 11:0.
// R07: modes are none, active, precharge, and precharge with dll off.
// R08: active mode drops cke with pages open, exit waits txp.
// R09: dll-off exit waits txpdll before first data.
// R10: precharge mode closes all banks first, pages empty after exit.
// R11: per-rank idle counter runs without accesses, entry only without new request.
// R12: idle counter restarts at each new transaction for the rank.
// R13: idle threshold counts dram clock cycles.
// R14: software default config value is 16'h6080.
// R15: config writes ignored once the register lock is set.
// R16: cke driven low during power-up.
// R17: cke stays low through reset until software sets the release bit.
// R18: new request wakes the rank; no command until exit latency passes.
module rpd_top #(
  parameter int unsigned RANKS = rpd_pkg::NUM_RANKS
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [RANKS-1:0]  RANK_REQ,
  input  wire logic [RANKS-1:0]  BANKS_CLOSED,
  output logic      [RANKS-1:0]  RANK_READY,
  output logic      [RANKS-1:0]  PRECHARGE_REQ,
  output logic      [RANKS-1:0]  PAGES_LOST,
  output logic      [RANKS-1:0]  CKE,
  output logic      [RANKS-1:0]  CKE_OE_N,
  output logic      [RANKS-1:0]  CLK_OE_N,
  output logic      [RANKS-1:0]  ODT_OE_N,
  output logic      [RANKS-1:0]  CS_OE_N
);

  typedef struct packed {
    logic [15:0]      power_down_config;
    logic             cke_release;
    logic             lock;
    logic [RANKS-1:0] populated;
    logic [4:0]       txp;
    logic [4:0]       txpdll;
    logic [31:0]      rdata;
    logic             slverr;
  } rpd_regs_t;

  rpd_regs_t r;
  rpd_regs_t next_r;

  logic             wr_access;
  logic             rd_access;
  logic [RANKS-1:0] cke_w;
  logic [RANKS-1:0] pd_w;
  logic [RANKS-1:0] ready_w;
  logic [RANKS-1:0] prech_w;
  logic [RANKS-1:0] lost_w;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_access = PSEL && PENABLE && !PWRITE;

  always_comb begin
    next_r        = r;
    next_r.slverr = 1'b0;
    if (wr_access) begin
      if (PADDR == rpd_pkg::OFF_PD_CFG) begin
        // lock freezes the configuration for the rest of the session
        if (!r.lock) begin // see R15
          if (PSTRB[0]) begin
            next_r.power_down_config[7:0] = PWDATA[7:0]; // see R06
          end
          if (PSTRB[1]) begin
            next_r.power_down_config[15:8] = PWDATA[15:8]; // see R05
          end
        end
      end else if (PADDR == rpd_pkg::OFF_CTRL) begin
        if (PSTRB[0]) begin
          // release bit only goes up; dropping cke again needs a reset
          next_r.cke_release = r.cke_release | PWDATA[rpd_pkg::CTRL_CKE_REL]; // see R17
          next_r.lock        = r.lock | PWDATA[rpd_pkg::CTRL_LOCK];
        end
      end else if (PADDR == rpd_pkg::OFF_POP) begin
        if (PSTRB[0]) begin
          next_r.populated = PWDATA[RANKS-1:0]; // see R03
        end
      end else if (PADDR == rpd_pkg::OFF_EXIT_LAT) begin
        if (!r.lock) begin
          if (PSTRB[0]) begin
            next_r.txp = PWDATA[4:0];
          end
          if (PSTRB[1]) begin
            next_r.txpdll = PWDATA[12:8];
          end
        end
      end else if (PADDR != rpd_pkg::OFF_STATUS) begin
        next_r.slverr = 1'b1;
      end
    end
    if (rd_access) begin
      next_r.rdata = 32'h0000_0000;
      if (PADDR == rpd_pkg::OFF_PD_CFG) begin
        next_r.rdata[15:0] = r.power_down_config;
      end else if (PADDR == rpd_pkg::OFF_CTRL) begin
        next_r.rdata[rpd_pkg::CTRL_CKE_REL] = r.cke_release;
        next_r.rdata[rpd_pkg::CTRL_LOCK]    = r.lock;
      end else if (PADDR == rpd_pkg::OFF_POP) begin
        next_r.rdata[RANKS-1:0] = r.populated;
      end else if (PADDR == rpd_pkg::OFF_STATUS) begin
        next_r.rdata[RANKS-1:0]     = cke_w;
        next_r.rdata[RANKS+7:8]     = pd_w;
        next_r.rdata[RANKS+15:16]   = ready_w;
        next_r.rdata[RANKS+23:24]   = lost_w;
      end else if (PADDR == rpd_pkg::OFF_EXIT_LAT) begin
        next_r.rdata[4:0]  = r.txp;
        next_r.rdata[12:8] = r.txpdll;
      end else begin
        next_r.slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r.power_down_config <= rpd_pkg::PD_CFG_RST;
      r.cke_release       <= 1'b0;
      r.lock              <= 1'b0;
      r.populated         <= {RANKS{1'b1}}; // see R02
      r.txp               <= rpd_pkg::TXP_RST;
      r.txpdll            <= rpd_pkg::TXPDLL_RST;
      r.rdata             <= 32'h0000_0000;
      r.slverr            <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // read data and error are registered, so the slave answers with one wait state
  logic ack;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack <= 1'b0;
    end else begin
      ack <= PSEL && PENABLE && !ack;
    end
  end

  assign PREADY  = ack;
  assign PRDATA  = r.rdata;
  assign PSLVERR = ack && r.slverr;

  ////////////////////////////////////////////////////////////////////////////////
  // one engine per rank

  for (genvar g = 0; g < RANKS; g++) begin : g_rank
    rpd_if rif ();
    assign rif.cke_release  = r.cke_release;
    assign rif.mode         = r.power_down_config[rpd_pkg::TYPE_MSB:rpd_pkg::TYPE_LSB]; // see R07
    assign rif.idle_thresh  = r.power_down_config[rpd_pkg::IDLE_MSB:rpd_pkg::IDLE_LSB];
    assign rif.txp          = r.txp;
    assign rif.txpdll       = r.txpdll;
    assign rif.req          = RANK_REQ[g];
    assign rif.banks_closed = BANKS_CLOSED[g];

    rpd_rank u_rank (
      .CLK   (CLK),
      .RST_N (RST_N),
      .rif   (rif)
    ); // see R04

    assign cke_w[g]   = rif.cke;
    assign pd_w[g]    = rif.powered_down;
    assign ready_w[g] = rif.ready;
    assign prech_w[g] = rif.precharge_req;
    assign lost_w[g]  = rif.pages_lost;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pads: empty ranks are released, others driven

  assign CKE           = cke_w;
  assign RANK_READY    = ready_w;
  assign PRECHARGE_REQ = prech_w;
  assign PAGES_LOST    = lost_w;
  assign CKE_OE_N      = ~r.populated; // see R01
  assign CLK_OE_N      = ~r.populated; // see R01
  assign ODT_OE_N      = ~r.populated; // see R01
  assign CS_OE_N       = ~r.populated; // see R01

endmodule

// >>> dv/rpd_asserts.sv
// port-level assertion checker for the rank power-down controller
`timescale 1ns/1ps
module rpd_asserts #(
  parameter int unsigned RANKS = 4
) (
  input wire logic             CLK,
  input wire logic             RST_N,
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  input wire logic [RANKS-1:0] RANK_REQ,
  input wire logic [RANKS-1:0] BANKS_CLOSED,
  input wire logic [RANKS-1:0] RANK_READY,
  input wire logic [RANKS-1:0] PRECHARGE_REQ,
  input wire logic [RANKS-1:0] CKE,
  input wire logic [RANKS-1:0] CKE_OE_N,
  input wire logic [RANKS-1:0] CLK_OE_N,
  input wire logic [RANKS-1:0] ODT_OE_N,
  input wire logic [RANKS-1:0] CS_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [RANKS-1:0] woke;
  // the first release of cke is not a power-down exit, so it is excluded
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      woke <= '0;
    end else begin
      woke <= woke | CKE;
    end
  end
  ////////////////////////////////////////
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  AST_APB_WAIT: assert property (s_access |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle after access");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_PAD_GROUP: assert property (CKE_OE_N == CLK_OE_N && ODT_OE_N == CS_OE_N
    && CKE_OE_N == CS_OE_N) else $error("pad enables of one rank differ");
  AST_RESET_DRIVEN: assert property ($rose(RST_N) |-> CKE_OE_N == '0)
    else $error("rank undriven after reset");
  AST_RESET_CKE_LOW: assert property ($rose(RST_N) |-> CKE == '0 ##1 CKE == '0)
    else $error("cke high right after reset");
  for (genvar i = 0; i < RANKS; i++) begin : g_rank
    AST_ENTRY_BANKS: assert property ($fell(CKE[i]) && $past(PRECHARGE_REQ[i])
      |-> $past(BANKS_CLOSED[i])) else $error("cke fell with banks open");
    AST_EXIT_WAIT: assert property ($rose(CKE[i]) && woke[i] |-> !RANK_READY[i] [*4])
      else $error("rank ready before exit latency");
    AST_UP_HOLD: assert property (RANK_REQ[i] && CKE[i] |=> CKE[i])
      else $error("power-down entered despite new request");
    AST_WAKE: assert property (RANK_REQ[i] && !CKE[i] && woke[i] |=> CKE[i])
      else $error("request did not wake rank");
    AST_READY_CKE: assert property (RANK_READY[i] |-> CKE[i])
      else $error("rank ready with cke low");
  end
endmodule

bind rpd_top rpd_asserts #(.RANKS(RANKS)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RANK_REQ(RANK_REQ), .BANKS_CLOSED(BANKS_CLOSED),
  .RANK_READY(RANK_READY), .PRECHARGE_REQ(PRECHARGE_REQ), .CKE(CKE),
  .CKE_OE_N(CKE_OE_N), .CLK_OE_N(CLK_OE_N), .ODT_OE_N(ODT_OE_N), .CS_OE_N(CS_OE_N)
);

// >>> dv/rpd_ranks_model.sv
// behavioural sdram ranks: close all banks some cycles after a precharge request
`timescale 1ns/1ps
module rpd_ranks_model #(
  parameter int unsigned RANKS = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             slow,
  input  wire logic [RANKS-1:0] precharge_req,
  output logic      [RANKS-1:0] banks_closed
);
  logic [3:0] pipe [RANKS];
  // banks reopen one cycle after the request drops (four cycles when slow), so a late entry would be caught
  always_ff @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < RANKS; i++) begin
      if (!rst_n) begin
        pipe[i] <= '0;
      end else begin
        pipe[i] <= {pipe[i][2:0], precharge_req[i]};
      end
    end
  end
  always_comb begin
    for (int i = 0; i < RANKS; i++) begin
      banks_closed[i] = slow ? pipe[i][3] : pipe[i][0];
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench for the rank power-down controller
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, err;
  logic        slow = 1'b0;
  logic [3:0]  req = 4'h0;
  logic [3:0]  closed, ready, pre, lost, cke, cke_oe_n, clk_oe_n, odt_oe_n, cs_oe_n;
  int          bad_count = 0;
  int          total_checks = 0;
  always #20 clk = ~clk;
  rpd_top DUT (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RANK_REQ(req), .BANKS_CLOSED(closed), .RANK_READY(ready),
    .PRECHARGE_REQ(pre), .PAGES_LOST(lost), .CKE(cke), .CKE_OE_N(cke_oe_n),
    .CLK_OE_N(clk_oe_n), .ODT_OE_N(odt_oe_n), .CS_OE_N(cs_oe_n));
  rpd_ranks_model u_ranks (.clk(clk), .rst_n(rst_n), .slow(slow), .precharge_req(pre),
    .banks_closed(closed));
  ////////////////////////////////////////
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      chk("wait bound", 0, 1);
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // flop outputs read right at the edge still show what that edge samples
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    err = pslverr;
    bound(pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, e);
  endtask
  task automatic pd_run(input logic [3:0] m, input int lat);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    apb(1'b1, rpd_pkg::OFF_PD_CFG, {16'h0, m, 12'h002});
    slow <= (m == 4'h6);
    @(posedge clk);
    req <= 4'h2;
    do begin
      @(posedge clk);
      #1;
      k++;
      seen |= pre[0];
    end while (cke[0] !== 1'b0 && k < 40);
    bound(k < 40);
    chk("cke per rank", cke, 4'h2);
    chk("pages lost", lost[0], m != 4'h1);
    if (m == 4'h1) chk("idle cycles", k, 3);
    else chk("precharge asked", seen, 1'b1);
    rd("status down", rpd_pkg::OFF_STATUS, {7'h0, m != 4'h1, 24'h02_0d02});
    @(posedge clk);
    req <= 4'h3;
    @(posedge clk);
    #1;
    chk("wake cke", cke[0], 1'b1);
    k = 0;
    while (ready[0] !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("exit latency", k, lat);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd("populated", rpd_pkg::OFF_POP, 32'hf);
    rd("config", rpd_pkg::OFF_PD_CFG, 32'h0);
    rd("exit lat", rpd_pkg::OFF_EXIT_LAT, 32'h1404);
    chk("pad enables", {cke_oe_n, clk_oe_n, odt_oe_n, cs_oe_n}, 16'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", err, 1'b1);
    repeat (20) @(posedge clk);
    req <= 4'hf;
    #1;
    chk("cke held", cke, 4'h0);
    apb(1'b1, rpd_pkg::OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("cke released", cke, 4'hf);
    pd_run(4'h1, 4);
    pd_run(4'h2, 4);
    pd_run(4'h6, 20);
    apb(1'b1, rpd_pkg::OFF_PD_CFG, 32'h0002);
    req <= 4'h0;
    repeat (10) @(posedge clk);
    #1;
    chk("no power-down", cke, 4'hf);
    rd("status up", rpd_pkg::OFF_STATUS, 32'h000f_000f);
    apb(1'b1, rpd_pkg::OFF_PD_CFG, 32'h6080);
    rd("config", rpd_pkg::OFF_PD_CFG, 32'h6080);
    apb(1'b1, rpd_pkg::OFF_CTRL, 32'h3);
    apb(1'b1, rpd_pkg::OFF_PD_CFG, 32'h1002);
    rd("locked config", rpd_pkg::OFF_PD_CFG, 32'h6080);
    apb(1'b1, rpd_pkg::OFF_EXIT_LAT, 32'h0101);
    rd("locked exit lat", rpd_pkg::OFF_EXIT_LAT, 32'h1404);
    // ranks 1 and 3 are treated as known empty here
    apb(1'b1, rpd_pkg::OFF_POP, 32'h5);
    #1;
    chk("empty ranks", {cke_oe_n, clk_oe_n, odt_oe_n, cs_oe_n}, 16'haaaa);
    summarize();
  end
endmodule
